// ==== rtl/erx_rx_path.sv ====
`timescale 1ns/1ps
`include "erx_cfg.svh"
module erx_rx_path
	import erx_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
) (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Global pins
	input  wire logic        hw_mode_select_enable_pin,
	input  wire logic        hw_mode_select_pin,
	input  wire logic        global_rx_impedance_pin,
	// Sliced line marks
	input  wire logic        rx_line_pos_input,
	input  wire logic        rx_line_neg_input,
	// Analog controls
	output logic      [1:0]  internal_term_resistor,
	output erx_term_e        term_mode,
	output erx_gain_e        monitor_gain,
	output logic             line_mode_e1,
	// System output
	output logic             rx_clk_out,
	output logic             rx_data_pos,
	output logic             rx_data_neg,
	output logic             rx_data_valid,
	input  wire logic        rx_data_ready
);
	logic [7:0]  chan_cfg_reg, chan_cfg_next;
	logic [7:0]  rx_cfg_a_reg, rx_cfg_a_next;
	logic [7:0]  rx_cfg_b_reg, rx_cfg_b_next;
	logic [7:0]  rx_cfg_c_reg, rx_cfg_c_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [4:0]  psync_reg, nsync_reg;
	logic [2:0]  p_s1, p_s2;
	logic [7:0]  phase_reg, phase_next;
	logic        clk_reg, clk_next;
	logic        tick;
	logic [3:0]  shp_reg, shp_next, shn_reg, shn_next;
	logic        lastpol_reg, lastpol_next;
	logic        dp_reg, dp_next, dn_reg, dn_next, vld_reg, vld_next;
	logic        fifo_in_ready, fifo_out_valid;
	logic [1:0]  fifo_out_data;
	logic [5:0]  fifo_level;
	logic        hdb3, decode_on;
	erx_out_mode_e out_mode;
	logic        apb_hit, pos_s, neg_s, edge_seen, mark, prev_pol;

	// Two-stage synchronisers for pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_s1 <= 3'h7;
			p_s2 <= 3'h7;
			psync_reg <= 5'h00;
		end else begin
			p_s1 <= {hw_mode_select_enable_pin, hw_mode_select_pin, global_rx_impedance_pin};
			p_s2 <= p_s1;
			psync_reg <= {psync_reg[3:0], rx_line_pos_input};
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nsync_reg <= 5'h00;
		end else begin
			nsync_reg <= {nsync_reg[3:0], rx_line_neg_input};
		end
	end
	assign pos_s = psync_reg[1];
	assign neg_s = nsync_reg[1];
	assign mark  = pos_s | neg_s;
	assign edge_seen = mark & ~(psync_reg[2] | nsync_reg[2]);

	// Mode and termination decode
	always_comb begin
		line_mode_e1 = p_s2[2] ? ~p_s2[1] : chan_cfg_reg[`ERX_BIT_LINE_MODE];
		internal_term_resistor = rx_cfg_a_reg[1:0];
		if (!p_s2[0]) begin
			term_mode = ERX_TERM_EXT;
			internal_term_resistor = 2'h0;
		end else if (rx_cfg_a_reg[`ERX_BIT_TERM_EXT]) begin
			term_mode = ERX_TERM_EXT;
			internal_term_resistor = 2'h0;
		end else begin
			term_mode = rx_cfg_a_reg[`ERX_BIT_RES_SEL] ? ERX_TERM_FULL : ERX_TERM_PART;
		end
		monitor_gain = erx_gain_e'(rx_cfg_c_reg[1:0]);
		out_mode = erx_out_mode_e'(rx_cfg_b_reg[1:0]);
		hdb3 = rx_cfg_b_reg[`ERX_BIT_RX_CODE];
		decode_on = (out_mode == ERX_OUT_SR_NRZ);
	end

	// APB register file, zero wait
	always_comb begin
		apb_hit = psel && penable;
		chan_cfg_next = chan_cfg_reg;
		rx_cfg_a_next = rx_cfg_a_reg;
		rx_cfg_b_next = rx_cfg_b_reg;
		rx_cfg_c_next = rx_cfg_c_reg;
		prdata_next = prdata_reg;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`ERX_OFS_CHAN_CFG: prdata_next = {24'h000000, chan_cfg_reg};
				`ERX_OFS_RX_CFG_A: prdata_next = {24'h000000, rx_cfg_a_reg};
				`ERX_OFS_RX_CFG_B: prdata_next = {24'h000000, rx_cfg_b_reg};
				`ERX_OFS_RX_CFG_C: prdata_next = {24'h000000, rx_cfg_c_reg};
				`ERX_OFS_STATUS:   prdata_next = {22'h000000, fifo_level, term_mode,
					line_mode_e1, fifo_out_valid};
				`ERX_OFS_RX_DATA:  prdata_next = {29'h00000000, fifo_out_valid, fifo_out_data};
				default:           prdata_next = 32'h00000000;
			endcase
		end
		if (apb_hit && pwrite) begin
			unique case (paddr)
				`ERX_OFS_CHAN_CFG: chan_cfg_next = {7'h00, pwdata[0]};
				`ERX_OFS_RX_CFG_A: rx_cfg_a_next = {3'h0, pwdata[4], 1'b0, pwdata[2:0]};
				`ERX_OFS_RX_CFG_B: rx_cfg_b_next = {5'h00, pwdata[2:0]};
				`ERX_OFS_RX_CFG_C: rx_cfg_c_next = {6'h00, pwdata[1:0]};
				default:           ;
			endcase
		end
	end
	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = apb_hit && !(paddr <= `ERX_OFS_RX_DATA && paddr[1:0] == 2'b00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_cfg_reg <= `ERX_RST_CHAN_CFG;
			rx_cfg_a_reg <= `ERX_RST_RX_CFG_A;
			rx_cfg_b_reg <= `ERX_RST_RX_CFG_B;
			rx_cfg_c_reg <= `ERX_RST_RX_CFG_C;
			prdata_reg   <= 32'h00000000;
		end else begin
			chan_cfg_reg <= chan_cfg_next;
			rx_cfg_a_reg <= rx_cfg_a_next;
			rx_cfg_b_reg <= rx_cfg_b_next;
			rx_cfg_c_reg <= rx_cfg_c_next;
			prdata_reg   <= prdata_next;
		end
	end

	// Clock recovery: free-running bit counter realigned by pulses
	always_comb begin
		phase_next = phase_reg + 8'h01;
		tick = 1'b0;
		if (edge_seen) begin
			phase_next = 8'(`ERX_BIT_CYC / 2);
		end else if (phase_reg == 8'(`ERX_BIT_CYC - 1)) begin
			phase_next = 8'h00;
			tick = 1'b1;
		end
		// Toggle only at natural crossings so a realign never cuts a pulse short
		clk_next = clk_reg;
		if (tick) begin
			clk_next = 1'b1;
		end else if (!edge_seen && phase_reg == 8'(`ERX_BIT_CYC / 2 - 1)) begin
			clk_next = 1'b0;
		end
	end

	// Decoder: four-symbol window, oldest symbol emitted each bit in ERX_OUT_SR_NRZ; the dual-rail modes pass the arriving symbol
	always_comb begin
		shp_next = shp_reg;
		shn_next = shn_reg;
		lastpol_next = lastpol_reg;
		dp_next = 1'b0;
		dn_next = 1'b0;
		vld_next = 1'b0;
		// Polarity of the newest mark before the arriving symbol
		if (shp_reg[0] | shn_reg[0]) begin
			prev_pol = shp_reg[0];
		end else if (shp_reg[1] | shn_reg[1]) begin
			prev_pol = shp_reg[1];
		end else if (shp_reg[2] | shn_reg[2]) begin
			prev_pol = shp_reg[2];
		end else if (shp_reg[3] | shn_reg[3]) begin
			prev_pol = shp_reg[3];
		end else begin
			prev_pol = lastpol_reg;
		end
		if (tick && !rx_data_valid_block()) begin
			shp_next = {shp_reg[2:0], pos_s};
			shn_next = {shn_reg[2:0], neg_s};
			if (decode_on) begin
				dp_next = shp_reg[3] | shn_reg[3];
				vld_next = 1'b1;
				if (shp_reg[3] | shn_reg[3]) begin
					lastpol_next = shp_reg[3];
				end
				if (hdb3 && (pos_s | neg_s) && (pos_s == prev_pol)) begin
					// Oldest symbol still leaves; the three held and the violation become zeros
					shp_next = 4'h0;
					shn_next = 4'h0;
					lastpol_next = pos_s;
				end
			end else begin
				dp_next = pos_s;
				dn_next = neg_s;
				vld_next = 1'b1;
			end
		end
	end

	function automatic logic rx_data_valid_block();
		return !fifo_in_ready;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= 8'h00;
			clk_reg <= 1'b0;
			shp_reg <= 4'h0;
			shn_reg <= 4'h0;
			lastpol_reg <= 1'b0;
			dp_reg <= 1'b0;
			dn_reg <= 1'b0;
			vld_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			clk_reg <= clk_next;
			shp_reg <= shp_next;
			shn_reg <= shn_next;
			lastpol_reg <= lastpol_next;
			dp_reg <= dp_next;
			dn_reg <= dn_next;
			vld_reg <= vld_next;
		end
	end
	assign rx_clk_out = clk_reg;

	erx_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (vld_reg),
		.in_ready  (fifo_in_ready),
		.in_data   ({dp_reg, dn_reg}),
		.out_valid (fifo_out_valid),
		.out_ready (rx_data_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);
	assign rx_data_valid = fifo_out_valid;
	assign rx_data_pos   = fifo_out_data[1];
	assign rx_data_neg   = fifo_out_data[0];
endmodule : erx_rx_path

// ==== rtl/erx_cfg.svh ====
`ifndef ERX_CFG_SVH
`define ERX_CFG_SVH
// Register byte offsets
`define ERX_OFS_CHAN_CFG     12'h000
`define ERX_OFS_RX_CFG_A     12'h004
`define ERX_OFS_RX_CFG_B     12'h008
`define ERX_OFS_RX_CFG_C     12'h00C
`define ERX_OFS_STATUS       12'h010
`define ERX_OFS_RX_DATA      12'h014
// Field positions
`define ERX_BIT_LINE_MODE    0
`define ERX_BIT_TERM_EXT     2
`define ERX_BIT_RES_SEL      4
`define ERX_BIT_RX_CODE      2
// Reset values
`define ERX_RST_CHAN_CFG     8'h00
`define ERX_RST_RX_CFG_A     8'h04
`define ERX_RST_RX_CFG_B     8'h00
`define ERX_RST_RX_CFG_C     8'h00
// Timing: bit period 488 ns (2.048 Mbit/s), recovered as 48 cycles (480 ns) of the 10 ns clock
`define ERX_BIT_NS           488
`define ERX_CLK_NS           10
`define ERX_BIT_CYC          (`ERX_BIT_NS / `ERX_CLK_NS)
`define ERX_LOCK_WIN         6
`endif

// ==== rtl/erx_pkg.sv ====
package erx_pkg;
	typedef enum logic [1:0] {
		ERX_OUT_SR_NRZ  = 2'b00,
		ERX_OUT_DR_NRZ  = 2'b01,
		ERX_OUT_DR_RZ   = 2'b10,
		ERX_OUT_DR_SLC  = 2'b11
	} erx_out_mode_e;
	typedef enum logic [1:0] {
		ERX_TERM_EXT    = 2'b00,
		ERX_TERM_PART   = 2'b01,
		ERX_TERM_FULL   = 2'b10
	} erx_term_e;
	typedef enum logic [1:0] {
		ERX_GAIN_0DB    = 2'b00,
		ERX_GAIN_20DB   = 2'b01,
		ERX_GAIN_26DB   = 2'b10,
		ERX_GAIN_32DB   = 2'b11
	} erx_gain_e;
endpackage : erx_pkg

// ==== rtl/erx_fifo.sv ====
`timescale 1ns/1ps
module erx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	// Flags and pointer arithmetic
	always_comb begin
		in_ready  = (cnt_reg != (AW+1)'(DEPTH));
		out_valid = (cnt_reg != '0);
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wr_next   = push ? wr_reg + 1'b1 : wr_reg;
		rd_next   = pop ? rd_reg + 1'b1 : rd_reg;
		cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		out_data  = mem[rd_reg];
		level     = cnt_reg;
	end

	// Pointer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end
endmodule : erx_fifo

// ==== testbench/erx_rx_path_properties.sv ====
`timescale 1ns/1ps
module erx_chk
	import erx_pkg::*;
(
	// Clock, reset and APB request
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Global pins
	input wire logic        hw_mode_select_enable_pin,
	input wire logic        hw_mode_select_pin,
	input wire logic        global_rx_impedance_pin,
	// Controls driven by the block
	input wire logic [1:0]  internal_term_resistor,
	input wire erx_term_e   term_mode,
	input wire erx_gain_e   monitor_gain,
	input wire logic        line_mode_e1,
	input wire logic        rx_clk_out
);
	logic [7:0] sh_reg  [4];
	logic [7:0] sh_next [4];
	logic [6:0] run_reg, run_next;
	logic       clk_reg;
	// Mirror register writes and count cycles since the clock last moved
	always_comb begin
		sh_next = sh_reg;
		if (psel && penable && pwrite && paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0) begin
			sh_next[paddr[3:2]] = pwdata[7:0];
		end
		run_next = (rx_clk_out != clk_reg) ? 7'h00 : run_reg + 7'h01;
	end
	// Register the mirror state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_reg  <= '{8'h00, 8'h04, 8'h00, 8'h00};
			run_reg <= 7'h00;
			clk_reg <= 1'b0;
		end else begin
			sh_reg  <= sh_next;
			run_reg <= run_next;
			clk_reg <= rx_clk_out;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Pins steady long enough to pass the synchroniser
	sequence rim_lo; !global_rx_impedance_pin [*3]; endsequence
	sequence rim_hi; global_rx_impedance_pin [*3]; endsequence
	rim_ext_a: assert property (rim_lo |-> term_mode == ERX_TERM_EXT)
		else $error("term not external with pin low");
	ext_code_a: assert property (rim_hi ##0 sh_reg[1][2] |-> term_mode == ERX_TERM_EXT)
		else $error("term not external with code b2 set");
	int_mode_a: assert property (rim_hi ##0 !sh_reg[1][2] |->
		term_mode == (sh_reg[1][4] ? ERX_TERM_FULL : ERX_TERM_PART)) else $error("bad internal mode");
	int_value_a: assert property (term_mode != ERX_TERM_EXT |->
		internal_term_resistor == sh_reg[1][1:0]) else $error("bad resistor value");
	pin_e1_a: assert property ((hw_mode_select_enable_pin && !hw_mode_select_pin) [*3]
		|-> line_mode_e1) else $error("pin mode not taken");
	pin_off_a: assert property ((hw_mode_select_enable_pin && hw_mode_select_pin) [*3]
		|-> !line_mode_e1) else $error("pin mode not taken");
	bit_mode_a: assert property (!hw_mode_select_enable_pin [*3] |->
		line_mode_e1 == sh_reg[0][0]) else $error("channel bit not taken");
	gain_sel_a: assert property (monitor_gain == erx_gain_e'(sh_reg[3][1:0]))
		else $error("bad monitor gain");
	clk_run_a: assert property (run_reg < 7'd100)
		else $error("recovered clock stopped");
	clk_half_a: assert property ($changed(rx_clk_out) |=> $stable(rx_clk_out) [*8])
		else $error("recovered clock too fast");
endmodule : erx_chk

bind erx_rx_path erx_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.hw_mode_select_enable_pin, .hw_mode_select_pin, .global_rx_impedance_pin,
	.internal_term_resistor, .term_mode, .monitor_gain, .line_mode_e1, .rx_clk_out);

// ==== testbench/erx_line_model.sv ====
`timescale 1ns/1ps
`include "erx_cfg.svh"
module erx_line_model (
	// Clock
	input wire logic pclk,
	// Sliced marks towards the receiver
	output logic     pos,
	output logic     neg
);
	// A quiet line carries spaces
	initial begin
		pos = 1'b0;
		neg = 1'b0;
	end
	// One symbol held a full bit period: +1 or -1 mark, 0 space
	task automatic sym(input int s);
		@(posedge pclk);
		pos <= (s > 0);
		neg <= (s < 0);
		repeat (`ERX_BIT_CYC - 1) @(posedge pclk);
	endtask : sym
endmodule : erx_line_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`include "erx_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t mismatch", $time); end end
module tb_top;
	import erx_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        hw_mode_select_enable_pin = 1, hw_mode_select_pin = 1;
	logic        global_rx_impedance_pin = 0, rx_line_pos_input, rx_line_neg_input;
	logic [1:0]  internal_term_resistor;
	erx_term_e   term_mode;
	erx_gain_e   monitor_gain;
	logic        line_mode_e1, rx_clk_out, rx_data_pos, rx_data_neg, rx_data_valid;
	logic        rx_data_ready = 1, err;
	int          fails = 0, n_checks = 0, np = 0, nn = 0;
	// legal codes only: {pin, b4, code}, full only with transformer
	logic [5:0]  tcase [6] = '{6'h02, 6'h22, 6'h32, 6'h23, 6'h24, 6'h33};

	erx_rx_path #(.FIFO_DEPTH(32)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .hw_mode_select_enable_pin, .hw_mode_select_pin,
		.global_rx_impedance_pin, .rx_line_pos_input, .rx_line_neg_input,
		.internal_term_resistor, .term_mode, .monitor_gain, .line_mode_e1, .rx_clk_out,
		.rx_data_pos, .rx_data_neg, .rx_data_valid, .rx_data_ready);
	erx_line_model u_line (.pclk, .pos(rx_line_pos_input), .neg(rx_line_neg_input));

	// Clock
	always #5 pclk = ~pclk;
	// Count ones taken from the receive queue
	always @(posedge pclk) begin
		if (rx_data_valid === 1'b1 && rx_data_ready) begin
			np += rx_data_pos;
			nn += rx_data_neg;
		end
	end
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Lock preamble, then + 0 0 0 V - with eight trailing spaces
	task automatic line_run(input logic [2:0] cfg);
		int k;
		apb(1'b1, `ERX_OFS_RX_CFG_B, {29'h0, cfg});
		for (k = 0; k < 12; k++) u_line.sym(k < 8 ? (k % 2 ? -1 : 1) : 0);
		@(negedge pclk);
		np = 0;
		nn = 0;
		for (k = 0; k < 14; k++) u_line.sym(k == 0 || k == 4 ? 1 : (k == 5 ? -1 : 0));
	endtask : line_run
	function automatic erx_term_e texp(input logic [5:0] c);
		return (!c[5] || c[2]) ? ERX_TERM_EXT : (c[4] ? ERX_TERM_FULL : ERX_TERM_PART);
	endfunction : texp
	task automatic finish_test();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// Cut a hang short well past the expected run length
	initial begin
		repeat (40000) @(posedge pclk);
		fails++;
		finish_test();
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, (i == 4) ? 12'h020 : 12'(i * 4), '0);
			`CHK(rd, (i == 1) ? 32'h4 : 32'h0)
			`CHK(err, i == 4)
		end
		foreach (tcase[i]) begin
			@(posedge pclk);
			global_rx_impedance_pin <= tcase[i][5];
			apb(1'b1, `ERX_OFS_RX_CFG_A, {27'h0, tcase[i][4:0]});
			repeat (4) @(negedge pclk);
			`CHK(term_mode, texp(tcase[i]))
			if (texp(tcase[i]) != ERX_TERM_EXT) `CHK(internal_term_resistor, tcase[i][1:0])
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			hw_mode_select_enable_pin <= !i[1];
			hw_mode_select_pin <= i[0];
			apb(1'b1, `ERX_OFS_CHAN_CFG, {31'h0, i[0]});
			repeat (4) @(negedge pclk);
			`CHK(line_mode_e1, i[0] ~^ i[1])
		end
		@(posedge pclk);
		hw_mode_select_enable_pin <= 1'b1;
		hw_mode_select_pin <= 1'b0;
		for (int g = 0; g < 4; g++) begin
			apb(1'b1, `ERX_OFS_RX_CFG_C, 32'(g));
			@(negedge pclk);
			`CHK(monitor_gain, erx_gain_e'(g))
		end
		for (int m = 0; m < 5; m++) begin
			line_run(m < 2 ? {m[0], 2'b00} : {1'b1, 2'(m - 1)});
			if (m < 2) `CHK(np, m ? 2 : 3)
			else `CHK(np * 4 + nn, 9)
		end
		// Stall the sink until the queue refuses, then drain it
		rx_data_ready <= 1'b0;
		repeat (40 * `ERX_BIT_CYC) @(posedge pclk);
		apb(1'b0, `ERX_OFS_STATUS, '0);
		`CHK(rd[9:4], 6'h20)
		rx_data_ready <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, `ERX_OFS_STATUS, '0);
		`CHK(rd[9:4] < 6'h02, 1'b1)
		finish_test();
	end
endmodule : tb_top
